/* File: rtl/fvd_pkg.sv */
package fvd_pkg;

  // ------------------------------------------------------------
  // vectors
  // ------------------------------------------------------------
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_DEV_NA = 8'h07;
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_RESERVED = 8'h09;
  localparam logic [7:0] VEC_TASK_STATE = 8'h0A;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
  localparam logic [7:0] VEC_STACK = 8'h0C;
  localparam logic [7:0] VEC_GEN_PROT = 8'h0D;
  localparam logic [7:0] VEC_PAGE = 8'h0E;

  // ------------------------------------------------------------
  // error codes
  // ------------------------------------------------------------
  localparam logic [15:0] ERR_ZERO = 16'h0000;
  // selector index keeps index and table bit, drops the low two bits
  localparam logic [15:0] SEL_INDEX_MASK = 16'hFFFC;

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SEG_DATA = 3'b000,
    SEG_CODE = 3'b001,
    SEG_STACK = 3'b010,
    SEG_LDT = 3'b011,
    SEG_TSS = 3'b100,
    SEG_GATE = 3'b101
  } fvd_seg_kind_t;

  typedef enum logic [1:0] {
    CTX_LOAD = 2'b00,
    CTX_TASK_SWITCH = 2'b01,
    CTX_GATE_STACK = 2'b10
  } fvd_ctx_t;

  typedef enum logic [1:0] {
    IP_FAULT_INSTR = 2'b00,
    IP_NEW_TASK = 2'b01,
    IP_UNDEFINED = 2'b10
  } fvd_ip_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_BENIGN = 3'b001,
    ST_CONTRIB = 3'b010,
    ST_PAGE = 3'b011,
    ST_DF_XFER = 3'b100,
    ST_SHUTDOWN = 3'b101
  } fvd_state_t;

endpackage : fvd_pkg

/* File: rtl/fvd_chk_if.sv */
`timescale 1ns/10ps
interface fvd_chk_if;
  fvd_pkg::fvd_seg_kind_t kind;
  fvd_pkg::fvd_ctx_t ctx;
  logic valid;
  logic [15:0] selector;
  logic outside;
  logic ldt_not_gdt;
  logic type_bad;
  logic present;
  logic conforming;
  logic [1:0] descriptor_privilege_level;
  logic [1:0] requested_privilege_level;
  logic [1:0] current_privilege_level;
  logic long_mode;
  logic before_load;
  logic hit;
  logic [7:0] vector;
  logic [15:0] err_code;
  fvd_pkg::fvd_ip_t ip_kind;

  modport req (
    output kind, ctx, valid, selector, outside, ldt_not_gdt, type_bad, present,
    output conforming, descriptor_privilege_level, requested_privilege_level, current_privilege_level, long_mode, before_load,
    input hit, vector, err_code, ip_kind
  );
  modport chk (
    input kind, ctx, valid, selector, outside, ldt_not_gdt, type_bad, present,
    input conforming, descriptor_privilege_level, requested_privilege_level, current_privilege_level, long_mode, before_load,
    output hit, vector, err_code, ip_kind
  );
endinterface : fvd_chk_if

/* File: rtl/fvd_seg_check.sv */
`timescale 1ns/10ps
module fvd_seg_check (
  fvd_chk_if.chk c
);

  function automatic logic [15:0] sel_index(input logic [15:0] sel);
    sel_index = sel & fvd_pkg::SEL_INDEX_MASK;
  endfunction : sel_index

  logic task_ctx;
  logic ts_fail;
  logic priv_bad;

  always_comb begin
    task_ctx = (c.ctx == fvd_pkg::CTX_TASK_SWITCH) && !c.long_mode;
    priv_bad = c.conforming ? (c.descriptor_privilege_level > c.current_privilege_level) : (c.descriptor_privilege_level != c.current_privilege_level);
    ts_fail = 1'b0;
    c.hit = 1'b0;
    c.vector = fvd_pkg::VEC_GEN_PROT;
    c.err_code = sel_index(c.selector);
    c.ip_kind = fvd_pkg::IP_FAULT_INSTR;
    if (c.valid && c.ctx == fvd_pkg::CTX_GATE_STACK) begin
      // inner stack fetch through a gate, in any mode
      if (c.kind == fvd_pkg::SEG_TSS) begin
        ts_fail = c.outside;
      end else begin
        ts_fail = c.outside || (c.descriptor_privilege_level != c.current_privilege_level) || (c.requested_privilege_level != c.current_privilege_level) || c.type_bad;
      end
      c.hit = ts_fail;
      c.vector = fvd_pkg::VEC_TASK_STATE;
    end else if (c.valid && task_ctx) begin
      case (c.kind)
        fvd_pkg::SEG_TSS: ts_fail = c.outside;
        fvd_pkg::SEG_LDT: begin
          ts_fail = c.ldt_not_gdt || c.outside || c.type_bad || !c.present;
        end
        fvd_pkg::SEG_CODE: ts_fail = c.outside || priv_bad || c.type_bad;
        fvd_pkg::SEG_DATA: ts_fail = c.outside || c.type_bad;
        fvd_pkg::SEG_STACK: begin
          ts_fail = c.outside || (c.descriptor_privilege_level != c.current_privilege_level) || (c.requested_privilege_level != c.current_privilege_level) || c.type_bad;
        end
        default: ts_fail = c.outside;
      endcase
      if (ts_fail) begin
        c.hit = 1'b1;
        c.vector = fvd_pkg::VEC_TASK_STATE;
        // limit check on the old state faults before any selector is loaded
        c.ip_kind = c.before_load ? fvd_pkg::IP_FAULT_INSTR : fvd_pkg::IP_NEW_TASK;
      end else if (!c.present) begin
        c.hit = 1'b1;
        c.vector = (c.kind == fvd_pkg::SEG_STACK) ? fvd_pkg::VEC_STACK
                                                  : fvd_pkg::VEC_NOT_PRESENT;
        c.ip_kind = fvd_pkg::IP_NEW_TASK;
      end
    end else if (c.valid && c.ctx == fvd_pkg::CTX_LOAD) begin
      if (c.outside || c.type_bad || (c.kind == fvd_pkg::SEG_CODE && priv_bad)) begin
        c.hit = 1'b1;
        c.vector = fvd_pkg::VEC_GEN_PROT;
      end else if (!c.present) begin
        c.hit = 1'b1;
        c.vector = (c.kind == fvd_pkg::SEG_STACK) ? fvd_pkg::VEC_STACK
                                                  : fvd_pkg::VEC_NOT_PRESENT;
      end
    end
  end

endmodule : fvd_seg_check

/* File: rtl/fvd_fault_detect.sv */
`timescale 1ns/10ps
module fvd_fault_detect (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control register bits
  input wire logic monitor_coprocessor_bit,
  input wire logic emulate_float_bit,
  input wire logic task_switched_bit,
  input wire logic long_mode,
  // instruction execution
  input wire logic instr_valid,
  input wire logic float_instr,
  input wire logic float_wait_instruction,
  input wire logic media_instr,
  input wire logic float_operand_fault,
  // segment loading
  input wire logic seg_valid,
  input wire fvd_pkg::fvd_seg_kind_t seg_kind,
  input wire fvd_pkg::fvd_ctx_t seg_ctx,
  input wire logic [15:0] seg_selector,
  input wire logic seg_outside,
  input wire logic seg_ldt_not_gdt,
  input wire logic seg_type_bad,
  input wire logic seg_present,
  input wire logic seg_conforming,
  input wire logic [1:0] seg_dpl,
  input wire logic [1:0] seg_rpl,
  input wire logic [1:0] seg_cpl,
  input wire logic seg_before_load,
  // other exceptions
  input wire logic ext_valid,
  input wire logic [7:0] ext_vector,
  input wire logic ext_err_valid,
  input wire logic [15:0] ext_err_code,
  // delivery and restart
  input wire logic deliver_done,
  input wire logic nmi,
  input wire logic nmi_handler_active,
  input wire logic init,
  // exception out
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic exc_err_valid,
  output logic [15:0] exc_err_code,
  output fvd_pkg::fvd_ip_t exc_ip_kind,
  output logic shutdown
);

  // ------------------------------------------------------------
  // classification
  // ------------------------------------------------------------
  function automatic logic is_contrib(input logic [7:0] v);
    is_contrib = (v == fvd_pkg::VEC_DIVIDE) || (v == fvd_pkg::VEC_TASK_STATE) ||
                 (v == fvd_pkg::VEC_NOT_PRESENT) || (v == fvd_pkg::VEC_STACK) ||
                 (v == fvd_pkg::VEC_GEN_PROT);
  endfunction : is_contrib

  typedef struct packed {
    fvd_pkg::fvd_state_t st;
    logic nmi_block;
    logic shut;
    logic valid;
    logic [7:0] vector;
    logic err_valid;
    logic [15:0] err_code;
    fvd_pkg::fvd_ip_t ip_kind;
  } fvd_regs_t;

  fvd_regs_t r;
  fvd_regs_t next_r;

  fvd_chk_if chk ();

  assign chk.kind = seg_kind;
  assign chk.ctx = seg_ctx;
  assign chk.valid = seg_valid;
  assign chk.selector = seg_selector;
  assign chk.outside = seg_outside;
  assign chk.ldt_not_gdt = seg_ldt_not_gdt;
  assign chk.type_bad = seg_type_bad;
  assign chk.present = seg_present;
  assign chk.conforming = seg_conforming;
  assign chk.descriptor_privilege_level = seg_dpl;
  assign chk.requested_privilege_level = seg_rpl;
  assign chk.current_privilege_level = seg_cpl;
  assign chk.long_mode = long_mode;
  assign chk.before_load = seg_before_load;

  fvd_seg_check u_seg_check (
    .c(chk.chk)
  );

  // ------------------------------------------------------------
  // candidate exception
  // ------------------------------------------------------------
  logic dev_na;
  logic cand_valid;
  logic [7:0] cand_vector;
  logic cand_err_valid;
  logic [15:0] cand_err_code;
  fvd_pkg::fvd_ip_t cand_ip;

  always_comb begin
    dev_na = instr_valid && (
      (float_wait_instruction && monitor_coprocessor_bit && task_switched_bit) ||
      (float_instr && (emulate_float_bit || task_switched_bit)) ||
      (media_instr && task_switched_bit));
    cand_valid = 1'b1;
    cand_vector = fvd_pkg::VEC_GEN_PROT;
    cand_err_valid = 1'b1;
    cand_err_code = fvd_pkg::ERR_ZERO;
    cand_ip = fvd_pkg::IP_FAULT_INSTR;
    // segment checks win: they belong to the oldest operation in flight
    if (chk.hit) begin
      cand_vector = chk.vector;
      cand_err_code = chk.err_code;
      cand_ip = chk.ip_kind;
    end else if (instr_valid && float_operand_fault) begin
      cand_vector = fvd_pkg::VEC_GEN_PROT;
    end else if (dev_na) begin
      cand_vector = fvd_pkg::VEC_DEV_NA;
      cand_err_valid = 1'b0;
    end else if (ext_valid && ext_vector != fvd_pkg::VEC_RESERVED) begin
      cand_vector = ext_vector;
      cand_err_valid = ext_err_valid;
      cand_err_code = ext_err_code;
    end else begin
      cand_valid = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // escalation
  // ------------------------------------------------------------
  logic cand_contrib;
  logic cand_page;
  logic escalate;

  always_comb begin
    cand_contrib = is_contrib(cand_vector);
    cand_page = (cand_vector == fvd_pkg::VEC_PAGE);
    escalate = ((r.st == fvd_pkg::ST_CONTRIB) && cand_contrib) ||
               ((r.st == fvd_pkg::ST_PAGE) && (cand_contrib || cand_page));
    next_r = r;
    next_r.valid = 1'b0;
    case (r.st)
      fvd_pkg::ST_SHUTDOWN: begin
        // held here until restart; nothing is delivered
        if (init || (nmi && !r.nmi_block)) begin
          next_r.st = fvd_pkg::ST_IDLE;
          next_r.nmi_block = 1'b0;
        end
      end
      fvd_pkg::ST_DF_XFER: begin
        if (cand_valid) begin
          next_r.st = fvd_pkg::ST_SHUTDOWN;
          next_r.nmi_block = nmi_handler_active;
        end else if (deliver_done) begin
          next_r.st = fvd_pkg::ST_IDLE;
        end
      end
      fvd_pkg::ST_IDLE, fvd_pkg::ST_BENIGN, fvd_pkg::ST_CONTRIB, fvd_pkg::ST_PAGE: begin
        if (cand_valid && escalate) begin
          next_r.st = fvd_pkg::ST_DF_XFER;
          next_r.valid = 1'b1;
          next_r.vector = fvd_pkg::VEC_DOUBLE;
          next_r.err_valid = 1'b1;
          next_r.err_code = fvd_pkg::ERR_ZERO;
          next_r.ip_kind = fvd_pkg::IP_UNDEFINED;
        end else if (cand_valid) begin
          // benign first event: the second simply follows it
          next_r.st = cand_page ? fvd_pkg::ST_PAGE :
                      cand_contrib ? fvd_pkg::ST_CONTRIB : fvd_pkg::ST_BENIGN;
          next_r.valid = 1'b1;
          next_r.vector = cand_vector;
          next_r.err_valid = cand_err_valid;
          next_r.err_code = cand_err_valid ? cand_err_code : fvd_pkg::ERR_ZERO;
          next_r.ip_kind = cand_ip;
        end else if (deliver_done) begin
          next_r.st = fvd_pkg::ST_IDLE;
        end
      end
      default: next_r.st = fvd_pkg::ST_IDLE;
    endcase
    // kept as its own flop so the pin needs no decode
    next_r.shut = (next_r.st == fvd_pkg::ST_SHUTDOWN);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{st: fvd_pkg::ST_IDLE, nmi_block: 1'b0, shut: 1'b0, valid: 1'b0,
             vector: fvd_pkg::VEC_DIVIDE, err_valid: 1'b0, err_code: fvd_pkg::ERR_ZERO,
             ip_kind: fvd_pkg::IP_FAULT_INSTR};
    end else begin
      r <= next_r;
    end
  end

  assign exc_valid = r.valid;
  assign exc_vector = r.vector;
  assign exc_err_valid = r.err_valid;
  assign exc_err_code = r.err_code;
  assign exc_ip_kind = r.ip_kind;
  assign shutdown = r.shut;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic live;
  assign live = (r.st != fvd_pkg::ST_DF_XFER) && (r.st != fvd_pkg::ST_SHUTDOWN) && !escalate;

  property p_nm_wait;
    @(posedge sys_clk) disable iff (sys_rst)
      exc_valid && exc_vector == fvd_pkg::VEC_DEV_NA && $past(float_wait_instruction)
      && !$past(float_instr) && !$past(media_instr)
      |-> $past(monitor_coprocessor_bit) && $past(task_switched_bit);
  endproperty
  a_nm_wait: assert property (p_nm_wait) else $error("wait fault without mp and ts");

  property p_nm_emulate;
    @(posedge sys_clk) disable iff (sys_rst)
      instr_valid && float_instr && emulate_float_bit && !chk.hit && !float_operand_fault && live
      |=> exc_valid && exc_vector == fvd_pkg::VEC_DEV_NA;
  endproperty
  a_nm_emulate: assert property (p_nm_emulate) else $error("emulate fault missing");

  property p_nm_media;
    @(posedge sys_clk) disable iff (sys_rst)
      instr_valid && media_instr && task_switched_bit && !chk.hit && !float_operand_fault && live
      |=> exc_valid && exc_vector == fvd_pkg::VEC_DEV_NA;
  endproperty
  a_nm_media: assert property (p_nm_media) else $error("media fault missing");

  property p_nm_noerr;
    @(posedge sys_clk) disable iff (sys_rst)
      exc_valid && exc_vector == fvd_pkg::VEC_DEV_NA
      |-> !exc_err_valid && exc_ip_kind == fvd_pkg::IP_FAULT_INSTR;
  endproperty
  a_nm_noerr: assert property (p_nm_noerr)
    else $error("device fault carries error code");

  property p_df_contrib;
    @(posedge sys_clk) disable iff (sys_rst)
      r.st == fvd_pkg::ST_CONTRIB && cand_valid && cand_contrib
      |=> exc_valid && exc_vector == fvd_pkg::VEC_DOUBLE ##1 !exc_valid;
  endproperty
  a_df_contrib: assert property (p_df_contrib)
    else $error("contributory pair not escalated");

  property p_df_page;
    @(posedge sys_clk) disable iff (sys_rst)
      r.st == fvd_pkg::ST_PAGE && cand_valid && (cand_contrib || cand_page)
      |=> exc_valid && exc_vector == fvd_pkg::VEC_DOUBLE;
  endproperty
  a_df_page: assert property (p_df_page) else $error("page fault pair not escalated");

  property p_benign_seq;
    @(posedge sys_clk) disable iff (sys_rst)
      r.st == fvd_pkg::ST_BENIGN && cand_valid
      |=> exc_valid && exc_vector == $past(cand_vector);
  endproperty
  a_benign_seq: assert property (p_benign_seq) else $error("benign first escalated");

  property p_shut;
    @(posedge sys_clk) disable iff (sys_rst)
      r.st == fvd_pkg::ST_DF_XFER && cand_valid |=> shutdown && !exc_valid;
  endproperty
  a_shut: assert property (p_shut) else $error("third fault did not shut down");

  property p_nmi_ignored;
    @(posedge sys_clk) disable iff (sys_rst)
      shutdown && r.nmi_block && !init |=> shutdown;
  endproperty
  a_nmi_ignored: assert property (p_nmi_ignored)
    else $error("nmi left blocked shutdown");

  property p_df_abort;
    @(posedge sys_clk) disable iff (sys_rst)
      exc_valid && exc_vector == fvd_pkg::VEC_DOUBLE
      |-> exc_err_valid && exc_err_code == fvd_pkg::ERR_ZERO
          && exc_ip_kind == fvd_pkg::IP_UNDEFINED;
  endproperty
  a_df_abort: assert property (p_df_abort) else $error("double fault code wrong");

  property p_no_reserved;
    @(posedge sys_clk) disable iff (sys_rst)
      exc_valid |-> exc_vector != fvd_pkg::VEC_RESERVED;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved vector raised");

  property p_stack_absent;
    @(posedge sys_clk) disable iff (sys_rst)
      seg_valid && seg_ctx == fvd_pkg::CTX_LOAD && seg_kind == fvd_pkg::SEG_STACK
      && !seg_present && !seg_outside && !seg_type_bad && live
      |=> exc_valid && exc_vector == fvd_pkg::VEC_STACK
          && exc_err_code == ($past(seg_selector) & fvd_pkg::SEL_INDEX_MASK);
  endproperty
  a_stack_absent: assert property (p_stack_absent)
    else $error("absent stack not stack fault");

  property p_np_load;
    @(posedge sys_clk) disable iff (sys_rst)
      seg_valid && seg_ctx == fvd_pkg::CTX_LOAD && seg_kind == fvd_pkg::SEG_DATA
      && !seg_present && !seg_outside && !seg_type_bad && live
      |=> exc_valid && exc_vector == fvd_pkg::VEC_NOT_PRESENT
          && exc_ip_kind == fvd_pkg::IP_FAULT_INSTR
          && exc_err_code == ($past(seg_selector) & fvd_pkg::SEL_INDEX_MASK);
  endproperty
  a_np_load: assert property (p_np_load) else $error("absent data not flagged");

  property p_ts_gate;
    @(posedge sys_clk) disable iff (sys_rst)
      seg_valid && seg_ctx == fvd_pkg::CTX_GATE_STACK && seg_kind == fvd_pkg::SEG_STACK
      && seg_dpl != seg_cpl && live
      |=> exc_valid && exc_vector == fvd_pkg::VEC_TASK_STATE
          && exc_ip_kind == fvd_pkg::IP_FAULT_INSTR;
  endproperty
  a_ts_gate: assert property (p_ts_gate) else $error("gate stack fault wrong");

  property p_nm_float_ts;
    @(posedge sys_clk) disable iff (sys_rst)
      instr_valid && float_instr && task_switched_bit && !chk.hit && !float_operand_fault
      && live |=> exc_valid && exc_vector == fvd_pkg::VEC_DEV_NA;
  endproperty
  a_nm_float_ts: assert property (p_nm_float_ts) else $error("float fault missing");

  c_df: cover property (@(posedge sys_clk) disable iff (sys_rst)
    exc_valid && exc_vector == fvd_pkg::VEC_DOUBLE);
  c_shut_nmi: cover property (@(posedge sys_clk) disable iff (sys_rst)
    shutdown ##1 !shutdown);
  c_ts: cover property (@(posedge sys_clk) disable iff (sys_rst)
    exc_valid && exc_vector == fvd_pkg::VEC_TASK_STATE && exc_ip_kind == fvd_pkg::IP_NEW_TASK);

endmodule : fvd_fault_detect

/* File: bench/fvd_deliver_model.sv */
`timescale 1ns/10ps
module fvd_deliver_model #(
  parameter int DELAY = 2
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // exception handed over
  input wire logic exc_valid,
  // hold off delivery so that nesting can be built up
  input wire logic stall,
  // completion
  output logic deliver_done
);
  logic pend;
  int cnt;

  // a new exception restarts the count, as a real delivery would restart
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend <= 1'b0;
      cnt <= 0;
      deliver_done <= 1'b0;
    end else begin
      deliver_done <= 1'b0;
      if (exc_valid) begin
        pend <= 1'b1;
        cnt <= 0;
      end else if (pend && !stall) begin
        if (cnt == DELAY - 1) begin
          pend <= 1'b0;
          deliver_done <= 1'b1;
        end else begin
          cnt <= cnt + 1;
        end
      end
    end
  end
endmodule : fvd_deliver_model

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic sys_clk, sys_rst, monitor_coprocessor_bit, emulate_float_bit, task_switched_bit;
  logic long_mode, instr_valid, float_instr, float_wait_instruction, media_instr;
  logic float_operand_fault, seg_valid, seg_outside, seg_ldt_not_gdt, seg_type_bad;
  logic seg_present, seg_conforming, seg_before_load, ext_valid, ext_err_valid;
  logic deliver_done, nmi, nmi_handler_active, init, exc_valid, exc_err_valid, shutdown, stall;
  fvd_pkg::fvd_seg_kind_t seg_kind;
  fvd_pkg::fvd_ctx_t seg_ctx;
  fvd_pkg::fvd_ip_t exc_ip_kind;
  logic [15:0] seg_selector, ext_err_code, exc_err_code;
  logic [1:0] seg_dpl, seg_rpl, seg_cpl;
  logic [7:0] ext_vector, exc_vector;
  int err_total, n_checks;

  fvd_fault_detect i_fvd_fault_detect (.sys_clk, .sys_rst, .monitor_coprocessor_bit,
    .emulate_float_bit, .task_switched_bit, .long_mode, .instr_valid, .float_instr,
    .float_wait_instruction, .media_instr, .float_operand_fault, .seg_valid, .seg_kind,
    .seg_ctx, .seg_selector, .seg_outside, .seg_ldt_not_gdt, .seg_type_bad, .seg_present,
    .seg_conforming, .seg_dpl, .seg_rpl, .seg_cpl, .seg_before_load, .ext_valid, .ext_vector,
    .ext_err_valid, .ext_err_code, .deliver_done, .nmi, .nmi_handler_active, .init,
    .exc_valid, .exc_vector, .exc_err_valid, .exc_err_code, .exc_ip_kind, .shutdown);

  fvd_deliver_model i_fvd_deliver_model (.sys_clk, .sys_rst, .exc_valid, .stall,
    .deliver_done);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // ip code 3 skips the pointer compare
  task automatic exp_exc(input logic [7:0] v, input logic ev, input logic [15:0] ec,
                         input logic [1:0] ip);
    chk("exc_valid", 16'(exc_valid), 16'h0001);
    chk("exc_vector", 16'(exc_vector), 16'(v));
    chk("exc_err_valid", 16'(exc_err_valid), 16'(ev));
    if (ev) chk("exc_err_code", exc_err_code, ec);
    if (ip != 2'h3) chk("exc_ip_kind", 16'(exc_ip_kind), 16'(ip));
  endtask : exp_exc

  task automatic no_exc;
    chk("exc_valid", 16'(exc_valid), 16'h0000);
  endtask : no_exc

  // k is float, wait, media, operand fault
  task automatic issue_instr(input logic [3:0] k);
    instr_valid = 1'b1;
    {float_instr, float_wait_instruction, media_instr, float_operand_fault} = k;
    tick(1);
    instr_valid = 1'b0;
    {float_instr, float_wait_instruction, media_instr, float_operand_fault} = 4'h0;
  endtask : issue_instr

  task automatic issue_ext(input logic [7:0] v, input logic [15:0] ec);
    ext_valid = 1'b1;
    ext_vector = v;
    ext_err_valid = 1'b1;
    ext_err_code = ec;
    tick(1);
    ext_valid = 1'b0;
  endtask : issue_ext

  // f is long mode, outside, ldt, type, present, conforming, before load; p is dpl rpl cpl
  task automatic issue_seg(input logic [2:0] k, input logic [1:0] c, input logic [6:0] f,
                           input logic [5:0] p);
    seg_valid = 1'b1;
    seg_kind = fvd_pkg::fvd_seg_kind_t'(k);
    seg_ctx = fvd_pkg::fvd_ctx_t'(c);
    seg_selector = 16'h1237;
    {long_mode, seg_outside, seg_ldt_not_gdt, seg_type_bad, seg_present, seg_conforming,
     seg_before_load} = f;
    {seg_dpl, seg_rpl, seg_cpl} = p;
    tick(1);
    seg_valid = 1'b0;
    long_mode = 1'b0;
  endtask : issue_seg

  // vector FF means no exception is expected
  task automatic seg_case(input logic [2:0] k, input logic [1:0] c, input logic [6:0] f,
                          input logic [5:0] p, input logic [7:0] xv, input logic [1:0] ip);
    issue_seg(k, c, f, p);
    if (xv == 8'hFF) no_exc();
    else exp_exc(xv, 1'b1, 16'h1234, ip);
    tick(6);
  endtask : seg_case

  task automatic wait_done;
    for (int n = 0; n < 20 && deliver_done !== 1'b1; n++) tick(1);
    tick(2);
  endtask : wait_done

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end

  initial begin
    logic hit;
    err_total = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    {monitor_coprocessor_bit, emulate_float_bit, task_switched_bit, long_mode} = 4'h0;
    {instr_valid, float_instr, float_wait_instruction, media_instr} = 4'h0;
    {float_operand_fault, seg_valid, seg_outside, seg_ldt_not_gdt, seg_type_bad} = 5'h00;
    {seg_present, seg_conforming, seg_before_load, ext_valid, ext_err_valid} = 5'h00;
    {nmi, nmi_handler_active, init, stall} = 4'h0;
    seg_kind = fvd_pkg::SEG_DATA;
    seg_ctx = fvd_pkg::CTX_LOAD;
    {seg_selector, ext_err_code, ext_vector} = 40'h0;
    {seg_dpl, seg_rpl, seg_cpl} = 6'h00;
    tick(8);
    sys_rst = 1'b0;
    tick(1);
    // wait and other float under every control bit mix, media only with the emulate bit clear
    for (int i = 0; i < 24; i++) begin
      {monitor_coprocessor_bit, emulate_float_bit, task_switched_bit} = i[2:0];
      hit = (i[4:3] == 0) ? (i[2] & i[0]) : (i[4:3] == 1) ? (i[1] | i[0]) : i[0];
      if (!(i[4:3] == 2 && i[1])) begin
        issue_instr(i[4:3] == 0 ? 4'h4 : i[4:3] == 1 ? 4'h8 : 4'h2);
        if (hit) exp_exc(8'h07, 1'b0, 16'h0000, 2'h0);
        else no_exc();
        tick(5);
      end
    end
    {monitor_coprocessor_bit, emulate_float_bit, task_switched_bit} = 3'h0;
    issue_instr(4'h1);
    exp_exc(8'h0D, 1'b1, 16'h0000, 2'h0);
    tick(5);
    issue_ext(8'h09, 16'h0000);
    no_exc();
    tick(5);
    $display("device not available test done");
    seg_case(3'h4, 2'h1, 7'h25, 6'h00, 8'h0A, 2'h0);
    seg_case(3'h4, 2'h2, 7'h24, 6'h00, 8'h0A, 2'h0);
    seg_case(3'h3, 2'h1, 7'h14, 6'h00, 8'h0A, 2'h1);
    seg_case(3'h3, 2'h1, 7'h0C, 6'h00, 8'h0A, 2'h1);
    seg_case(3'h1, 2'h1, 7'h06, 6'h30, 8'h0A, 2'h1);
    seg_case(3'h1, 2'h1, 7'h04, 6'h1A, 8'h0A, 2'h1);
    seg_case(3'h1, 2'h1, 7'h06, 6'h1A, 8'hFF, 2'h0);
    seg_case(3'h1, 2'h1, 7'h0C, 6'h00, 8'h0A, 2'h1);
    seg_case(3'h0, 2'h1, 7'h24, 6'h00, 8'h0A, 2'h1);
    seg_case(3'h0, 2'h1, 7'h0C, 6'h00, 8'h0A, 2'h1);
    seg_case(3'h2, 2'h1, 7'h04, 6'h04, 8'h0A, 2'h1);
    seg_case(3'h2, 2'h2, 7'h04, 6'h10, 8'h0A, 2'h0);
    seg_case(3'h2, 2'h2, 7'h44, 6'h10, 8'h0A, 2'h0);
    seg_case(3'h1, 2'h1, 7'h64, 6'h00, 8'hFF, 2'h0);
    seg_case(3'h0, 2'h0, 7'h00, 6'h00, 8'h0B, 2'h0);
    for (int k = 1; k < 6; k++) begin
      if (k != 2) seg_case(3'(k), 2'h0, 7'h00, 6'h00, 8'h0B, 2'h0);
    end
    seg_case(3'h2, 2'h0, 7'h00, 6'h00, 8'h0C, 2'h0);
    seg_case(3'h0, 2'h1, 7'h00, 6'h00, 8'h0B, 2'h1);
    seg_case(3'h0, 2'h0, 7'h04, 6'h00, 8'hFF, 2'h0);
    $display("segment test done");
    stall = 1'b1;
    seg_case(3'h4, 2'h1, 7'h25, 6'h00, 8'h0A, 2'h0);
    issue_ext(8'h0B, 16'h0058);
    exp_exc(8'h08, 1'b1, 16'h0000, 2'h2);
    tick(1);
    issue_ext(8'h00, 16'h0000);
    no_exc();
    chk("shutdown", 16'(shutdown), 16'h0001);
    tick(1);
    issue_ext(8'h0D, 16'h0000);
    no_exc();
    nmi = 1'b1;
    for (int n = 0; n < 4 && shutdown !== 1'b0; n++) tick(1);
    nmi = 1'b0;
    chk("shutdown", 16'(shutdown), 16'h0000);
    stall = 1'b0;
    tick(6);
    stall = 1'b1;
    issue_ext(8'h0E, 16'h0006);
    exp_exc(8'h0E, 1'b1, 16'h0006, 2'h3);
    tick(1);
    issue_ext(8'h0E, 16'h0004);
    exp_exc(8'h08, 1'b1, 16'h0000, 2'h2);
    stall = 1'b0;
    wait_done();
    issue_ext(8'h0D, 16'h0000);
    exp_exc(8'h0D, 1'b1, 16'h0000, 2'h3);
    tick(6);
    stall = 1'b1;
    issue_ext(8'h0E, 16'h0002);
    exp_exc(8'h0E, 1'b1, 16'h0002, 2'h3);
    issue_seg(3'h0, 2'h0, 7'h00, 6'h00);
    exp_exc(8'h08, 1'b1, 16'h0000, 2'h2);
    nmi_handler_active = 1'b1;
    issue_ext(8'h0D, 16'h0000);
    chk("shutdown", 16'(shutdown), 16'h0001);
    nmi = 1'b1;
    tick(4);
    nmi = 1'b0;
    chk("shutdown", 16'(shutdown), 16'h0001);
    init = 1'b1;
    tick(2);
    init = 1'b0;
    chk("shutdown", 16'(shutdown), 16'h0000);
    nmi_handler_active = 1'b0;
    stall = 1'b0;
    tick(6);
    $display("escalation test done");
    stall = 1'b1;
    task_switched_bit = 1'b1;
    issue_instr(4'h2);
    exp_exc(8'h07, 1'b0, 16'h0000, 2'h0);
    issue_ext(8'h0D, 16'h0010);
    exp_exc(8'h0D, 1'b1, 16'h0010, 2'h3);
    task_switched_bit = 1'b0;
    stall = 1'b0;
    tick(6);
    $display("benign test done");
    report_and_stop();
  end
endmodule : tb
